// ### core/mtg_pkg.sv
// Purpose: Shared constants and types of the march test pattern generator
// Assumes: Bit-organised RAM under test with 16K cells
// Notes:   Counter width follows the chain of four 4-bit stages
package mtg_pkg;

	// ****************************************************************
	// Sizes
	// ****************************************************************
	localparam int ADDR_W     = 14;
	localparam int STAGE_W    = 4;
	localparam int STAGES     = 4;
	localparam int CNT_W      = STAGE_W * STAGES;
	localparam int DATA_POS   = 14;
	localparam int END_POS    = 15;
	localparam int DISP_W     = 7;
	localparam int SYNC_DEPTH = 2;

	// ****************************************************************
	// Reset values
	// ****************************************************************
	localparam logic [CNT_W-1:0]   CNT_RESET  = 16'h0000;
	localparam logic [STAGE_W-1:0] STAGE_ZERO = 4'h0;
	localparam logic [ADDR_W-1:0]  ADDR_ZERO  = 14'h0000;
	localparam logic [DISP_W-1:0]  DISP_ZERO  = 7'h00;

	// Gray coded along idle, clear, march, done
	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'h0,
		ST_CLEAR = 2'h1,
		ST_MARCH = 2'h3,
		ST_DONE  = 2'h2
	} mtg_state_type;

endpackage : mtg_pkg

// ### core/mtg_count4.sv
// Purpose: One synchronous 4-bit binary counter stage with carry out
// Assumes: Stages are cascaded by feeding carry out to the next enable
// Notes:   Synchronous clear wins over counting
`timescale 1ns/10ps
module mtg_count4
	import mtg_pkg::*;
(
	input  wire logic               clock,
	input  wire logic               reset,
	input  wire logic               ce,
	input  wire logic               clr,
	input  wire logic               en,
	output logic      [STAGE_W-1:0] q,
	output logic                    tc
);

	logic [STAGE_W-1:0] q_reg;

	always_ff @(posedge clock)
	begin
		if (reset)
			q_reg <= STAGE_ZERO;
		else if (ce)
		begin
			if (clr)
				q_reg <= STAGE_ZERO;
			else if (en)
				q_reg <= q_reg + 4'h1;
		end
	end

	assign q  = q_reg;
	// Terminal carry ripples the enable into the next stage
	assign tc = en & (&q_reg);

endmodule : mtg_count4

// ### core/mtg_march_gen.sv
// Purpose: March pattern generator with fail-bit map outputs
// Assumes: RAM read data settles within one clock of a stable address
// Notes:   Read data is a pin and is synchronised before it is judged
`timescale 1ns/10ps

// How it works
// - Each pass first clears every cell to background zero.
// - Every read compares the returned bit with the expected one.
// - Upward from address zero: read background, then write complement.
// - Second march repeats with zero and one exchanged.
// - Whole test is clear plus two read-write marches: five N.
// - Address comes from four cascaded synchronous 4-bit counters.
// - Counter bit above the top address bit is the data value.
// - Test ends on carry into the sequence end bit.
// - March holds each address two clocks; clear holds one.
// - Address outputs feed an X-Y display converter.
// - Fail output modulates display intensity, aligned with address.
module mtg_march_gen
	import mtg_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              reset,
	input  wire logic              ce,
	input  wire logic              start,
	output logic      [ADDR_W-1:0] mem_addr,
	output logic                   mem_we,
	output logic                   mem_wdata,
	input  wire logic              mem_rdata,
	output logic                   pattern_data_bit,
	output logic                   sequence_end_bit,
	output logic      [DISP_W-1:0] disp_x,
	output logic      [DISP_W-1:0] disp_y,
	output logic                   disp_z,
	output logic                   busy,
	output logic                   done,
	output logic                   any_fail
);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	mtg_state_type      state_reg;
	mtg_state_type      state_next;
	logic [CNT_W-1:0]   cnt;
	logic [STAGES-1:0]  stage_tc;
	logic [STAGES:0]    stage_en;
	logic               half_reg;
	logic               step;
	logic               cnt_clr;
	logic               addr_wrap;
	logic               end_hit;
	logic               read_slot;
	logic [SYNC_DEPTH-1:0] rd_sync_reg;
	logic               p1_valid_reg;
	logic               p1_exp_reg;
	logic [ADDR_W-1:0]  p1_addr_reg;
	logic               p2_valid_reg;
	logic               p2_exp_reg;
	logic [ADDR_W-1:0]  p2_addr_reg;
	logic               mismatch;
	logic               fail_pulse_reg;
	logic [DISP_W-1:0]  disp_x_reg;
	logic [DISP_W-1:0]  disp_y_reg;
	logic               done_reg;
	logic               any_fail_reg;

	// ****************************************************************
	// Address counter chain
	// ****************************************************************
	// Clear steps every clock; march steps on the write half only
	assign step = (state_reg == ST_CLEAR) |
		((state_reg == ST_MARCH) & half_reg);
	assign stage_en[0] = step;

	genvar gi;
	generate
		for (gi = 0; gi < STAGES; gi++)
		begin : g_stage
			mtg_count4 u_stage
			(
				.clock (clock),
				.reset (reset),
				.ce    (ce),
				.clr   (cnt_clr),
				.en    (stage_en[gi]),
				.q     (cnt[gi*STAGE_W +: STAGE_W]),
				.tc    (stage_tc[gi])
			);
			assign stage_en[gi+1] = stage_tc[gi];
		end
	endgenerate

	// End of one full address sweep
	assign addr_wrap = step & (&cnt[ADDR_W-1:0]);
	// Carry into the end bit: last write of the second march
	assign end_hit = (state_reg == ST_MARCH) & step &
		(&cnt[END_POS-1:0]);
	// After the clear sweep the chain restarts at zero so that the data
	// bit is zero for the first march
	assign cnt_clr = start | ((state_reg == ST_CLEAR) & addr_wrap);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE:
				state_next = ST_IDLE;
			ST_CLEAR:
				if (addr_wrap)
					state_next = ST_MARCH;
			ST_MARCH:
				if (end_hit)
					state_next = ST_DONE;
			ST_DONE:
				state_next = ST_DONE;
			default:
				state_next = ST_IDLE;
		endcase
		if (start)
			state_next = ST_CLEAR;
	end

	always_ff @(posedge clock)
	begin
		if (reset)
			state_reg <= ST_IDLE;
		else if (ce)
			state_reg <= state_next;
	end

	// Toggle stage halves the address rate during the marches
	always_ff @(posedge clock)
	begin
		if (reset)
			half_reg <= 1'b0;
		else if (ce)
		begin
			if (start || state_reg != ST_MARCH)
				half_reg <= 1'b0;
			else
				half_reg <= ~half_reg;
		end
	end

	// ****************************************************************
	// Memory drive
	// ****************************************************************
	assign mem_addr         = cnt[ADDR_W-1:0];
	assign pattern_data_bit = cnt[DATA_POS];
	assign sequence_end_bit = cnt[END_POS];
	// First half reads the background, second half writes its complement
	assign read_slot = (state_reg == ST_MARCH) & ~half_reg;
	assign mem_we = (state_reg == ST_CLEAR) |
		((state_reg == ST_MARCH) & half_reg);
	// Clear writes zero; march writes the complement of the data bit
	assign mem_wdata = (state_reg == ST_MARCH) & ~cnt[DATA_POS];

	// ****************************************************************
	// Read check
	// ****************************************************************
	// Read data comes off a pin, so two flops precede any use
	always_ff @(posedge clock)
	begin
		if (reset)
			rd_sync_reg <= 2'h0;
		else if (ce)
			rd_sync_reg <= {rd_sync_reg[0], mem_rdata};
	end

	// Expected value and address travel alongside the synchroniser
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			p1_valid_reg <= 1'b0;
			p1_exp_reg   <= 1'b0;
			p1_addr_reg  <= ADDR_ZERO;
			p2_valid_reg <= 1'b0;
			p2_exp_reg   <= 1'b0;
			p2_addr_reg  <= ADDR_ZERO;
		end
		else if (ce)
		begin
			p1_valid_reg <= read_slot & ~start;
			p1_exp_reg   <= cnt[DATA_POS];
			p1_addr_reg  <= cnt[ADDR_W-1:0];
			p2_valid_reg <= p1_valid_reg & ~start;
			p2_exp_reg   <= p1_exp_reg;
			p2_addr_reg  <= p1_addr_reg;
		end
	end

	// Both polarities are checked at every cell, so a cell stuck at
	// either level fails in one of the two marches
	assign mismatch = p2_valid_reg &
		(rd_sync_reg[SYNC_DEPTH-1] != p2_exp_reg);

	// ****************************************************************
	// Fail-bit map display
	// ****************************************************************
	always_ff @(posedge clock)
	begin
		if (reset)
		begin
			fail_pulse_reg <= 1'b0;
			disp_x_reg     <= DISP_ZERO;
			disp_y_reg     <= DISP_ZERO;
		end
		else if (ce)
		begin
			fail_pulse_reg <= mismatch & ~start;
			disp_x_reg     <= p2_addr_reg[DISP_W-1:0];
			disp_y_reg     <= p2_addr_reg[ADDR_W-1:DISP_W];
		end
	end

	assign disp_x = disp_x_reg;
	assign disp_y = disp_y_reg;
	assign disp_z = fail_pulse_reg;

	// ****************************************************************
	// Status flags
	// ****************************************************************
	// Done waits for the last read to leave the check pipeline
	always_ff @(posedge clock)
	begin
		if (reset)
			done_reg <= 1'b0;
		else if (ce)
		begin
			if (start)
				done_reg <= 1'b0;
			else if (state_reg == ST_DONE && !p1_valid_reg &&
				!p2_valid_reg)
				done_reg <= 1'b1;
		end
	end

	// A mismatch in the start cycle is masked by start itself
	always_ff @(posedge clock)
	begin
		if (reset)
			any_fail_reg <= 1'b0;
		else if (ce)
		begin
			if (start)
				any_fail_reg <= 1'b0;
			else if (mismatch)
				any_fail_reg <= 1'b1;
		end
	end

	assign done     = done_reg;
	assign any_fail = any_fail_reg;
	assign busy     = (state_reg == ST_CLEAR) | (state_reg == ST_MARCH);

endmodule : mtg_march_gen

// ### sim/mtg_march_sva.sv
// Purpose: Port assertions for the march pattern generator
// Assumes: One clock domain, synchronous active high reset
// Notes:   Bound to every instance of the generator
`timescale 1ns/10ps
module mtg_march_sva
	import mtg_pkg::*;
(
	input wire logic              clock,
	input wire logic              reset,
	input wire logic              ce,
	input wire logic              start,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic              mem_we,
	input wire logic              mem_wdata,
	input wire logic              pattern_data_bit,
	input wire logic              sequence_end_bit,
	input wire logic              disp_z,
	input wire logic              busy,
	input wire logic              done,
	input wire logic              any_fail
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	// ****************************************************************
	// Steps of a test
	// ****************************************************************
	sequence s_take;
		start && ce;
	endsequence
	sequence s_read;
		busy && !mem_we && ce && !start;
	endsequence
	sequence s_write;
		busy && mem_we && ce && !start;
	endsequence

	a_start_clears: assert property (s_take |=> busy && mem_we
		&& mem_addr == ADDR_ZERO && !mem_wdata && !done && !any_fail)
		else $error("start did not clear the generator");
	a_read_then_write: assert property (s_read |=> mem_we
		&& mem_wdata == !pattern_data_bit && $stable(mem_addr))
		else $error("read not followed by complement write");
	a_addr_steps: assert property (s_write |=>
		mem_addr == $past(mem_addr) + 14'h0001)
		else $error("address did not step by one after a write");
	a_data_bit_wrap: assert property ($changed(pattern_data_bit) |->
		mem_addr == ADDR_ZERO)
		else $error("data bit changed away from an address wrap");
	a_fail_marks: assert property (disp_z |-> any_fail)
		else $error("fail pulse without sticky fail flag");
	a_done_sticky: assert property (done && !start |=> done && !busy)
		else $error("done flag dropped or busy while done");
	a_fail_sticky: assert property (any_fail && !start |=> any_fail)
		else $error("fail flag dropped without start");
	a_end_done: assert property ($rose(sequence_end_bit) |->
		!busy ##[0:6] done)
		else $error("end of sequence did not stop and raise done");
endmodule : mtg_march_sva

bind mtg_march_gen mtg_march_sva u_sva (.*);

// ### sim/mtg_ram_model.sv
// Purpose: Bit-organised RAM under test with one optional stuck cell
// Assumes: Combinational read, write on the rising edge
// Notes:   A stuck cell always reads its stuck level, as a solid fault
`timescale 1ns/10ps
module mtg_ram_model
	import mtg_pkg::*;
(
	input  wire logic              clock,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic              we,
	input  wire logic              wdata,
	input  wire logic              stuck_en,
	input  wire logic [ADDR_W-1:0] stuck_addr,
	input  wire logic              stuck_val,
	output logic                   rdata
);
	logic cell_mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge clock)
	begin
		if (we)
		begin
			cell_mem[addr] <= wdata;
		end
	end

	assign rdata = (stuck_en && addr == stuck_addr) ? stuck_val
		: cell_mem[addr];
endmodule : mtg_ram_model

// ### sim/tb_top.sv
// Purpose: Self-checking bench for the march pattern generator
// Assumes: One random stuck cell in the RAM model during the full test
// Notes:   Expected fail addresses are queued and matched by a monitor
`timescale 1ns/10ps
module tb_top
	import mtg_pkg::*;
;
	logic              clock, reset, ce, start, rdata, we, wdata, pdb;
	logic              seb, z, busy, done, any_fail, stuck_en, stuck_val;
	logic [ADDR_W-1:0] addr, stuck_addr;
	logic [DISP_W-1:0] dx, dy;
	logic [15:0]       rng;
	logic [ADDR_W-1:0] exp_q[$];
	int                failures, num_checks, busy_cycles, write_cycles;
	int                ce_highs;

	mtg_march_gen dut (.clock(clock), .reset(reset), .ce(ce), .start(start),
		.mem_addr(addr), .mem_we(we), .mem_wdata(wdata), .mem_rdata(rdata),
		.pattern_data_bit(pdb), .sequence_end_bit(seb), .disp_x(dx),
		.disp_y(dy), .disp_z(z), .busy(busy), .done(done),
		.any_fail(any_fail));
	mtg_ram_model ram (.clock(clock), .addr(addr), .we(we), .wdata(wdata),
		.stuck_en(stuck_en), .stuck_addr(stuck_addr),
		.stuck_val(stuck_val), .rdata(rdata));

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic [15:0] xorshift(input logic [15:0] v);
		logic [15:0] r;
		r = v ^ (v << 7);
		r = r ^ (r >> 9);
		xorshift = r ^ (r << 8);
	endfunction : xorshift

	task automatic check_val(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value %s expected %0h seen %0h", what, exp, got);
		end
	endtask : check_val

	task automatic check_map(input logic [ADDR_W-1:0] exp,
		input logic [ADDR_W-1:0] got);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value fail map expected %0h seen %0h", exp, got);
		end
	endtask : check_map

	task automatic tally_and_finish;
		if (failures == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Watchdog covers one full test plus margin
	initial
	begin
		#5000000;
		failures++;
		tally_and_finish();
	end

	// Outputs only move on rising edges, so falling edges see them settled
	always @(negedge clock)
	begin
		if (busy === 1'b1)
			busy_cycles++;
		if (busy === 1'b1 && we === 1'b1)
			write_cycles++;
		if (z === 1'b1 && exp_q.size() == 0)
			check_val("spurious fail", 32'h0, 32'h1);
		else if (z === 1'b1)
			check_map(exp_q.pop_front(), {dy, dx});
	end

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial
	begin
		reset = 1'b1;
		ce = 1'b1;
		start = 1'b0;
		stuck_en = 1'b0;
		stuck_addr = ADDR_ZERO;
		stuck_val = 1'b0;
		failures = 0;
		num_checks = 0;
		ce_highs = 0;
		rng = 16'h0B0A;
		repeat (5) @(negedge clock);
		reset = 1'b0;
		@(negedge clock);
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		repeat (40)
		begin
			rng = xorshift(rng);
			ce = rng[0];
			ce_highs += rng[0];
			@(negedge clock);
		end
		ce = 1'b1;
		check_val("busy", 32'h1, busy);
		// Clear steps once per enabled clock, so the address counts them
		check_val("frozen addr", ce_highs, addr);
		rng = xorshift(rng);
		stuck_addr = rng[ADDR_W-1:0];
		stuck_val = rng[15];
		stuck_en = 1'b1;
		exp_q.push_back(stuck_addr);
		// Restart in mid-clear: the full test counts from here
		start = 1'b1;
		@(posedge clock);
		#1;
		busy_cycles = 0;
		write_cycles = 0;
		@(negedge clock);
		start = 1'b0;
		check_val("restart addr", ADDR_ZERO, addr);
		check_val("restart write", 32'h1, we);
		check_val("restart data", 32'h0, wdata);
		for (int i = 0; i < 90000 && done !== 1'b1; i++)
			@(negedge clock);
		check_val("done", 32'h1, done);
		check_val("any fail", 32'h1, any_fail);
		check_val("end bit", 32'h1, seb);
		check_val("data bit", 32'h0, pdb);
		check_val("busy cycles", 32'h14000, busy_cycles);
		check_val("write cycles", 32'h0C000, write_cycles);
		check_val("fails left", 32'h0, exp_q.size());
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		check_val("done cleared", 32'h0, done);
		check_val("fail cleared", 32'h0, any_fail);
		// Reset in the first clear cycle, at address zero, returns the generator to idle at address zero
		reset = 1'b1;
		@(negedge clock);
		reset = 1'b0;
		check_val("reset busy", 32'h0, busy);
		check_val("reset addr", ADDR_ZERO, addr);
		check_val("reset write", 32'h0, we);
		tally_and_finish();
	end
endmodule : tb_top
